/* hdl/rcs_pkg.sv */
// Purpose: shared constants and types of the reset cause sequencer
// Assumes: 50 MHz system clock
// Notes: register offsets are byte addresses on the plain register port
package rcs_pkg;
  // clock rate and timing figures
  localparam int CLK_MHZ = 50;
  localparam int BIAS_US = 10;
  localparam int BIAS_CYC = BIAS_US * CLK_MHZ;
  localparam int MON_US = 100;
  localparam int MON_CYC = MON_US * CLK_MHZ;
  localparam int PU4_MS = 4;
  localparam int PU16_MS = 16;
  localparam int PU64_MS = 64;
  localparam int PU4_CYC = PU4_MS * 1000 * CLK_MHZ;
  localparam int PU16_CYC = PU16_MS * 1000 * CLK_MHZ;
  localparam int PU64_CYC = PU64_MS * 1000 * CLK_MHZ;
  localparam int TW = 22;
  localparam int FILT_CYC = 8;
  localparam int BCW = 10;
  //////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] REG_CAUSE = 4'h0;
  localparam logic [AW-1:0] REG_BORCTL = 4'h4;
  localparam logic [AW-1:0] REG_STATUS = 4'h8;
  // cause flag positions
  localparam int F_POR = 0;
  localparam int F_BOR = 1;
  localparam int F_IDLE = 2;
  localparam int F_SLEEP = 3;
  localparam int F_WDTO = 4;
  localparam int F_SWR = 6;
  localparam int F_EXTR = 7;
  localparam int F_IOPU = 14;
  localparam int F_TRAP = 15;
  localparam logic [DW-1:0] CAUSE_RST = 16'h0003;
  localparam logic [DW-1:0] CAUSE_MASK = 16'hc0df;
  localparam logic [2:0] BORCTL_RST = 3'h1;
  localparam int ST_LOCK = 5;
  //////////////////////////////////////////////////////////////////////////////
  // clock groups and primary modes
  localparam logic [2:0] GRP_FRC = 3'h1;
  localparam logic [2:0] GRP_PRI = 3'h7;
  localparam logic [4:0] PM_PLL4 = 5'h01;
  localparam logic [4:0] PM_PLL8 = 5'h0a;
  localparam logic [4:0] PM_PLL16 = 5'h03;
  localparam logic [4:0] PM_EXTCLK = 5'h0b;
  localparam logic [4:0] PM_EXTRC = 5'h08;
  localparam logic [1:0] PU_NONE = 2'h0;
  localparam logic [1:0] PU_4 = 2'h1;
  localparam logic [1:0] PU_16 = 2'h2;
  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_BIAS = 3'b001,
    ST_POWER_UP_TIMER = 3'b010,
    ST_CLKW = 3'b011,
    ST_Q1 = 3'b100,
    ST_RUN = 3'b101
  } rcs_state_t;
endpackage

/* hdl/rcs_tmr_if.sv */
// Purpose: load and expiry signals between sequencer and delay timer
// Assumes: one clock domain
// Notes: expired is high whenever the count stands at zero
`timescale 1ns/1ps
interface rcs_tmr_if;
  import rcs_pkg::*;
  logic load;
  logic [TW-1:0] val;
  logic expired;
  modport ctl (output load, output val, input expired);
  modport tmr (input load, input val, output expired);
endinterface

/* hdl/rcs_timer.sv */
// Purpose: down counter for bias, power-up and monitor delays
// Assumes: load is a one-cycle pulse with a nonzero value
// Notes: expired rises exactly val cycles after the load edge
`timescale 1ns/1ps
module rcs_timer (
  input wire logic mclk,
  input wire logic rst_n,
  rcs_tmr_if.tmr t
);
  import rcs_pkg::*;
  logic [TW-1:0] cnt_ff;
  //////////////////////////////////////////////////////////////////////////////
  // count down to zero and stop there
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (t.load) begin
      cnt_ff <= t.val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  // zero count means delay done
  assign t.expired = (cnt_ff == '0);
endmodule // rcs_timer

/* hdl/rcs_pin_filter.sv */
// Purpose: synchroniser and glitch filter for the external reset pin
// Assumes: pin is active low and asynchronous to mclk
// Notes: a new level must persist FILT_CYC cycles before it is taken
`timescale 1ns/1ps
module rcs_pin_filter #(
  parameter int FILT_CYC = rcs_pkg::FILT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pinRaw_n,
  output logic resetReq
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic sync1_ff;
  logic sync2_ff;
  logic req_ff;
  logic [CW-1:0] cnt_ff;
  //////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser, idle high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= pinRaw_n;
      sync2_ff <= sync1_ff;
    end
  end
  // short pulses reset the counter and never reach the output
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      req_ff <= 1'b0;
    end else if (!sync2_ff == req_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(FILT_CYC - 1)) begin
      cnt_ff <= '0;
      req_ff <= !sync2_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign resetReq = req_ff;
endmodule // rcs_pin_filter

/* hdl/rcs_reset_seq.sv */
// Purpose: reset source merging, release sequencing and cause flags
// Assumes: core strobes swResetReq, trapLockup, illegalOp for one mclk cycle
// Notes: cause flags survive every reset except rst_n and a power-on event, which both load CAUSE_RST
// What this block does
// - keep each reset cause apart
// - watchdog wake-up resumes without reset
// - cause flags record which source fired
// - filter short pulses on reset pin
// - never drive the reset pin
// - power-on restarts timer, reloads clock fuses
// - bias settle delay after power-on
// - selectable power-up timeout after bias delay
// - release on first phase, load vector
// - monitor traps and selects fast oscillator
// - no monitor, no timer: leave fast
// - no monitor, no clock: stay frozen
// - brown-out trip level selectable, resets device
// - brown-out reloads clock selection from fuses
// - brown-out starts oscillator timer, holds clock
// - hold clock until PLL locks
// - delays run beside clock hold
// - zero timeout with crystal uses monitor delay
// - brown-out sets its status flag
// - brown-out active in sleep and idle
// - software reads, writes, clears cause flags
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module rcs_reset_seq #(
  parameter int PU4_CYC = rcs_pkg::PU4_CYC,
  parameter int PU16_CYC = rcs_pkg::PU16_CYC,
  parameter int PU64_CYC = rcs_pkg::PU64_CYC,
  parameter int MON_CYC = rcs_pkg::MON_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic porPulse,
  input wire logic extResetPin_n,
  input wire logic borBelow,
  input wire logic wdtTimeout,
  input wire logic swResetReq,
  input wire logic trapLockup,
  input wire logic illegalOp,
  input wire logic sleepMode,
  input wire logic idleMode,
  input wire logic fscmEn,
  input wire logic [1:0] puTimeoutSel,
  input wire logic [2:0] oscGroupCfg,
  input wire logic [4:0] primaryModeCfg,
  input wire logic oscRunning,
  input wire logic ostExpired,
  input wire logic pllLock,
  input wire logic [rcs_pkg::AW-1:0] regAddr,
  input wire logic [rcs_pkg::DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [rcs_pkg::DW-1:0] regRdata,
  output logic systemReset,
  output logic pcLoadVector,
  output logic clkFailTrap,
  output logic wdtWakeup,
  output logic [2:0] clkGroupSel,
  output logic [4:0] primaryModeSel,
  output logic clkHold,
  output logic ostStart,
  output logic borEnable,
  output logic [1:0] borLevelSel,
  output logic resetPinOe
);
  import rcs_pkg::*;

  logic [2:0] asyncIn;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] prev_ff;
  logic pinReq, pinPrev_ff, borPrev_ff;
  logic porS, borS, wdtS, borLvl;
  logic porEv, borEv, wdtEv, pinEv, wdtRst, wdtWake, resetReq;
  logic [DW-1:0] cause_ff, nxt_cause, rdata_ff;
  logic borEnable_ff;
  logic [1:0] borLevel_ff;
  rcs_state_t state_ff, nxt_state;
  logic tmrLoad, trapNow, releaseNow;
  logic [TW-1:0] tmrVal, puCyc;
  logic systemReset_ff, pcLoadVector_ff, clkFailTrap_ff, wdtWakeup_ff;
  logic [2:0] clkGroupSel_ff;
  logic [4:0] primaryModeSel_ff;
  logic clkHold_ff, ostStart_ff, resetPinOe_ff, coldSeq_ff;
  logic [1:0] phase_ff;
  logic q1En, extOsc, crystal, pllUsed, clkReady;
  logic [BCW-1:0] biasCnt_ff;
  rcs_tmr_if tmr ();

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for por, brown-out and watchdog levels
  assign asyncIn = {wdtTimeout, borBelow, porPulse};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
      end else begin
        sync1_ff[i] <= asyncIn[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // filtered, synchronised pin request
  rcs_pin_filter #(.FILT_CYC(FILT_CYC)) u_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinRaw_n(extResetPin_n),
    .resetReq(pinReq)
  );

  // delayed copies for edge detection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_ff <= 3'h0;
      pinPrev_ff <= 1'b0;
      borPrev_ff <= 1'b0;
    end else begin
      prev_ff <= sync2_ff;
      pinPrev_ff <= pinReq;
      borPrev_ff <= borLvl;
    end
  end

  // reset sources and their events
  assign porS = sync2_ff[0];
  assign borS = sync2_ff[1];
  assign wdtS = sync2_ff[2];
  assign borLvl = borEnable_ff & borS;
  assign porEv = porS & !prev_ff[0];
  assign borEv = borLvl & !borPrev_ff;
  assign wdtEv = wdtS & !prev_ff[2];
  assign pinEv = pinReq & !pinPrev_ff;
  assign wdtWake = wdtEv & sleepMode;
  assign wdtRst = wdtEv & !sleepMode;
  assign resetReq = porS | borLvl | pinReq | wdtRst | swResetReq | trapLockup | illegalOp;

  //////////////////////////////////////////////////////////////////////////////
  // cause flags: software write first, hardware events win over it
  always_comb begin
    nxt_cause = cause_ff;
    if (regWr && regAddr == REG_CAUSE) begin
      nxt_cause = regWdata & CAUSE_MASK;
    end
    if (trapLockup) begin
      nxt_cause[F_TRAP] = 1'b1;
    end
    if (illegalOp) begin
      nxt_cause[F_IOPU] = 1'b1;
    end
    if (wdtWake) begin
      nxt_cause[F_WDTO] = 1'b1;
      nxt_cause[F_SLEEP] = 1'b1;
    end
    if (wdtRst || swResetReq) begin
      nxt_cause[F_EXTR] = 1'b0;
      nxt_cause[F_SWR] = swResetReq;
      nxt_cause[F_WDTO] = wdtRst;
      nxt_cause[F_IDLE] = 1'b0;
      nxt_cause[F_SLEEP] = 1'b0;
    end
    if (pinEv) begin
      nxt_cause[F_EXTR] = 1'b1;
      nxt_cause[F_WDTO] = 1'b0;
      nxt_cause[F_IDLE] = idleMode;
      nxt_cause[F_SLEEP] = sleepMode;
      if (!sleepMode && !idleMode) begin
        nxt_cause[F_SWR] = 1'b0;
      end
    end
    if (borEv) begin
      nxt_cause[F_POR] = 1'b0;
      nxt_cause[F_BOR] = 1'b1;
    end
    if (porEv) begin
      nxt_cause = CAUSE_RST;
    end
  end

  // flag register and brown-out control
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cause_ff <= CAUSE_RST;
      {borLevel_ff, borEnable_ff} <= BORCTL_RST;
    end else begin
      cause_ff <= nxt_cause;
      if (regWr && regAddr == REG_BORCTL) begin
        {borLevel_ff, borEnable_ff} <= regWdata[2:0];
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_CAUSE: rdata_ff <= cause_ff;
        REG_BORCTL: rdata_ff <= {13'h0000, borLevel_ff, borEnable_ff};
        REG_STATUS: rdata_ff <= {8'h00, systemReset_ff, state_ff, 1'b0, pllLock,
                                 clkHold_ff, clkGroupSel_ff == GRP_FRC};
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock readiness from the latched selection
  assign extOsc = (clkGroupSel_ff == GRP_PRI);
  assign crystal = extOsc && primaryModeSel_ff != PM_EXTCLK && primaryModeSel_ff != PM_EXTRC;
  assign pllUsed = extOsc && (primaryModeSel_ff == PM_PLL4 || primaryModeSel_ff == PM_PLL8 ||
                              primaryModeSel_ff == PM_PLL16);
  assign clkReady = !extOsc || (oscRunning && (!crystal || ostExpired) &&
                                (!pllUsed || pllLock));

  // four-phase divider, first phase enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end
  assign q1En = (phase_ff == 2'h0);

  // power-up timeout choice
  always_comb begin
    case (puTimeoutSel)
      PU_NONE: puCyc = '0;
      PU_4: puCyc = TW'(PU4_CYC);
      PU_16: puCyc = TW'(PU16_CYC);
      default: puCyc = TW'(PU64_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // release sequence
  always_comb begin
    nxt_state = state_ff;
    tmrLoad = 1'b0;
    tmrVal = '0;
    trapNow = 1'b0;
    releaseNow = 1'b0;
    if (resetReq) begin
      nxt_state = ST_HOLD;
    end else begin
      case (state_ff)
        ST_HOLD: begin
          if (coldSeq_ff) begin
            nxt_state = ST_BIAS;
            tmrLoad = 1'b1;
            tmrVal = TW'(BIAS_CYC);
          end else begin
            nxt_state = ST_Q1;
          end
        end
        ST_BIAS: begin
          if (tmr.expired) begin
            if (puCyc != '0) begin
              nxt_state = ST_POWER_UP_TIMER;
              tmrLoad = 1'b1;
              tmrVal = puCyc;
            end else if (crystal) begin
              nxt_state = ST_POWER_UP_TIMER;
              tmrLoad = 1'b1;
              tmrVal = TW'(MON_CYC);
            end else begin
              nxt_state = ST_CLKW;
            end
          end
        end
        ST_POWER_UP_TIMER: begin
          if (tmr.expired) begin
            nxt_state = ST_CLKW;
          end
        end
        ST_CLKW: begin
          if (clkReady) begin
            nxt_state = ST_Q1;
          end else if (fscmEn) begin
            trapNow = 1'b1;
            nxt_state = ST_Q1;
          end
        end
        ST_Q1: begin
          if (q1En) begin
            nxt_state = ST_RUN;
            releaseNow = 1'b1;
          end
        end
        ST_RUN: nxt_state = ST_RUN;
        default: nxt_state = ST_HOLD;
      endcase
    end
  end
  assign tmr.load = tmrLoad;
  assign tmr.val = tmrVal;

  // shared delay timer
  rcs_timer u_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .t(tmr)
  );

  // state register and cold-start marker
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_HOLD;
      coldSeq_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (porEv || borEv) begin
        coldSeq_ff <= 1'b1;
      end else if (releaseNow) begin
        coldSeq_ff <= 1'b0;
      end
    end
  end

  // system reset and the vector load, trap, wake and oscillator-start strobes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      systemReset_ff <= 1'b1;
      pcLoadVector_ff <= 1'b0;
      clkFailTrap_ff <= 1'b0;
      wdtWakeup_ff <= 1'b0;
      ostStart_ff <= 1'b0;
    end else begin
      if (resetReq) begin
        systemReset_ff <= 1'b1;
      end else if (releaseNow) begin
        systemReset_ff <= 1'b0;
      end
      pcLoadVector_ff <= releaseNow;
      clkFailTrap_ff <= trapNow;
      wdtWakeup_ff <= wdtWake;
      ostStart_ff <= (state_ff == ST_HOLD) && !resetReq && coldSeq_ff && crystal;
    end
  end

  // clock selection, reloaded from fuses on cold start, fast osc on trap
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clkGroupSel_ff <= GRP_FRC;
      primaryModeSel_ff <= 5'h00;
      clkHold_ff <= 1'b0;
      resetPinOe_ff <= 1'b0;
    end else begin
      if (trapNow) begin
        clkGroupSel_ff <= GRP_FRC;
      end else if (state_ff == ST_HOLD && coldSeq_ff) begin
        clkGroupSel_ff <= oscGroupCfg;
        primaryModeSel_ff <= primaryModeCfg;
      end
      clkHold_ff <= extOsc && !clkReady;
      resetPinOe_ff <= 1'b0;
    end
  end

  // output ports
  assign regRdata = rdata_ff;
  assign systemReset = systemReset_ff;
  assign pcLoadVector = pcLoadVector_ff;
  assign clkFailTrap = clkFailTrap_ff;
  assign wdtWakeup = wdtWakeup_ff;
  assign clkGroupSel = clkGroupSel_ff;
  assign primaryModeSel = primaryModeSel_ff;
  assign clkHold = clkHold_ff;
  assign ostStart = ostStart_ff;
  assign borEnable = borEnable_ff;
  assign borLevelSel = borLevel_ff;
  assign resetPinOe = resetPinOe_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge mclk) begin
    if (!rst_n || state_ff != ST_BIAS) begin
      biasCnt_ff <= '0;
    end else begin
      biasCnt_ff <= biasCnt_ff + 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_pin_never_drive: assert property (!resetPinOe_ff) else $error("pin driven");
  chk_release_on_phase: assert property ($fell(systemReset_ff) |-> $past(q1En))
    else $error("release off phase");
  chk_vector_with_release: assert property ($fell(systemReset_ff) |-> pcLoadVector_ff)
    else $error("no vector load");
  chk_bias_length: assert property ((state_ff == ST_BIAS && nxt_state != ST_BIAS &&
    !resetReq) |-> biasCnt_ff == BCW'(BIAS_CYC)) else $error("bias length wrong");
  chk_timeout_pick: assert property ((state_ff == ST_BIAS && tmr.expired && !resetReq &&
    puTimeoutSel == 2'h3) |=> state_ff == ST_POWER_UP_TIMER && !tmr.expired) else $error("timeout");
  chk_monitor_delay: assert property ((state_ff == ST_BIAS && tmr.expired && !resetReq &&
    puTimeoutSel == PU_NONE && crystal) |-> tmrVal == TW'(MON_CYC)) else $error("monitor");
  chk_trap_frc: assert property (clkFailTrap_ff |-> clkGroupSel_ff == GRP_FRC)
    else $error("trap without fast osc");
  chk_frozen_clock: assert property ((state_ff == ST_CLKW && !fscmEn && !clkReady &&
    !resetReq) |=> state_ff == ST_CLKW && systemReset_ff) else $error("left freeze");
  chk_bor_flag: assert property (borEv |=> cause_ff[F_BOR]) else $error("bor flag");
  chk_wake_run: assert property ((wdtWake && !resetReq && state_ff == ST_RUN) |=>
    state_ff == ST_RUN && !systemReset_ff) else $error("wake caused reset");
  chk_reset_at_once: assert property (resetReq |=> systemReset_ff)
    else $error("reset late");
  cov_release: cover property ($fell(systemReset_ff));
  cov_trap: cover property (clkFailTrap_ff);
  cov_wake: cover property (wdtWakeup_ff);
  cov_brownout: cover property (borEv ##1 systemReset_ff);
endmodule // rcs_reset_seq

/* dv/rcs_osc_model.sv */
// Purpose: oscillator, start-up timer and lock model beside the reset sequencer
// Assumes: ostStart is a one-cycle pulse from the sequencer
// Notes: slow keeps the oscillator stopped, so the clock never becomes ready
`timescale 1ns/1ps
module rcs_osc_model #(
  parameter int OST_DLY = 30
) (
  input wire logic mclk,
  input wire logic slow,
  input wire logic ostStart,
  output logic oscRunning,
  output logic ostExpired,
  output logic pllLock
);
  int cnt = 0;
  //////////////////////////////////////////////////////////////////////////////
  // start-up count restarts on each start pulse and stalls while stopped
  always @(posedge mclk) begin
    if (ostStart) begin
      cnt <= OST_DLY;
    end else if (cnt != 0 && !slow) begin
      cnt <= cnt - 1;
    end
  end
  // a stopped oscillator never reports expiry or lock
  assign oscRunning = !slow;
  assign ostExpired = (cnt == 0) && !slow;
  assign pllLock = ostExpired;
endmodule // rcs_osc_model

/* dv/rcs_reset_seq_bench.sv */
// Purpose: self-checking bench for the reset cause sequencer
// Assumes: short power-up counts set by parameter, bias fixed at 500 cycles
// Notes: release windows are counted in cycles from the last stimulus edge
`timescale 1ns/1ps
module rcs_reset_seq_bench;
  import rcs_pkg::*;
  logic mclk = 0, rst_n = 0, porPulse = 0, extResetPin_n = 1, borBelow = 0;
  logic wdtTimeout = 0, swResetReq = 0, trapLockup = 0, illegalOp = 0;
  logic sleepMode = 0, idleMode = 0, fscmEn = 0, regWr = 0, regRd = 0, slow = 0;
  logic [1:0] puTimeoutSel = 2'h1;
  logic [2:0] oscGroupCfg = GRP_FRC;
  logic [4:0] primaryModeCfg = 5'h00;
  logic [AW-1:0] regAddr = 4'h0;
  logic [DW-1:0] regWdata = 16'h0000;
  logic [DW-1:0] regRdata, d;
  logic systemReset, pcLoadVector, clkFailTrap, wdtWakeup, clkHold, ostStart;
  logic borEnable, resetPinOe, oscRunning, ostExpired, pllLock;
  logic [2:0] clkGroupSel;
  logic [4:0] primaryModeSel;
  logic [1:0] borLevelSel;
  int miscompares = 0, comparisons = 0, seed = 22, n, hi, wk;
  bit sawTrap;
  logic [15:0] evExp [4] = '{16'h0040, 16'h8000, 16'h4000, 16'h0010};

  // 50 MHz clock
  always #10 mclk = ~mclk;

  rcs_reset_seq #(.PU4_CYC(40), .PU16_CYC(60), .PU64_CYC(80), .MON_CYC(20)) rcs_reset_seq_i (
    .mclk, .rst_n, .porPulse, .extResetPin_n, .borBelow, .wdtTimeout, .swResetReq,
    .trapLockup, .illegalOp, .sleepMode, .idleMode, .fscmEn, .puTimeoutSel, .oscGroupCfg,
    .primaryModeCfg, .oscRunning, .ostExpired, .pllLock, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .systemReset, .pcLoadVector, .clkFailTrap, .wdtWakeup, .clkGroupSel,
    .primaryModeSel, .clkHold, .ostStart, .borEnable, .borLevelSel, .resetPinOe);
  rcs_osc_model rcs_osc_model_i (.mclk, .slow, .ostStart, .oscRunning, .ostExpired, .pllLock);

  //////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  // bounded wait for release, noting any clock fail trap meanwhile
  task automatic wait_rel(input int bound, output int cnt);
    cnt = 0;
    sawTrap = 0;
    while (systemReset !== 1'b0 && cnt < bound) begin
      @(posedge mclk);
      #1;
      cnt++;
      if (clkFailTrap === 1'b1) begin
        sawTrap = 1;
      end
    end
  endtask
  task automatic rel(input int lo, input int hiLim);
    int c;
    wait_rel(5000, c);
    if (c >= 5000) begin
      miscompares++;
      close_out();
    end
    check(16'(c >= lo && c <= hiLim), 16'h1);
    check(pcLoadVector, 1'b1);
  endtask
  // supply dip of ten cycles, then release inside a window
  task automatic bor_rel(input int lo, input int hiLim);
    @(posedge mclk);
    borBelow <= 1'b1;
    repeat (10) @(posedge mclk);
    borBelow <= 1'b0;
    #1 check(systemReset, 1'b1);
    rel(lo, hiLim);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rel(540, 560);
    rdchk(REG_CAUSE, CAUSE_RST);
    rdchk(REG_BORCTL, 16'h0001);
    rdchk(4'hc, 16'h0000);
    check(resetPinOe, 1'b0);
    $display("test power-up done");
    // random flag writes, masked readback, unmapped place
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      wr(REG_CAUSE, d);
      rdchk(REG_CAUSE, d & CAUSE_MASK);
    end
    wr(4'hc, 16'hffff);
    rdchk(4'hc, 16'h0000);
    wr(REG_BORCTL, 16'h0005);
    @(posedge mclk);
    #1 check({borLevelSel, borEnable}, 3'h5);
    $display("test registers done");
    // core and watchdog resets, one flag each
    for (int k = 0; k < 4; k++) begin
      wr(REG_CAUSE, 16'h0000);
      @(posedge mclk);
      case (k)
        0: swResetReq <= 1'b1;
        1: trapLockup <= 1'b1;
        2: illegalOp <= 1'b1;
        default: wdtTimeout <= 1'b1;
      endcase
      @(posedge mclk);
      {swResetReq, trapLockup, illegalOp} <= 3'h0;
      if (k == 3) begin
        repeat (3) @(posedge mclk);
      end
      #1 check(systemReset, 1'b1);
      rel(1, 12);
      @(posedge mclk);
      wdtTimeout <= 1'b0;
      rdchk(REG_CAUSE, evExp[k]);
    end
    $display("test core resets done");
    // short pin pulse filtered, long one in sleep resets
    wr(REG_CAUSE, 16'h0000);
    @(posedge mclk);
    extResetPin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    extResetPin_n <= 1'b1;
    hi = 0;
    repeat (20) begin
      @(posedge mclk);
      #1 hi += (systemReset !== 1'b0);
    end
    check(16'(hi), 16'h0);
    @(posedge mclk);
    extResetPin_n <= 1'b0;
    sleepMode <= 1'b1;
    repeat (20) @(posedge mclk);
    extResetPin_n <= 1'b1;
    #1 check(systemReset, 1'b1);
    check(resetPinOe, 1'b0);
    rel(1, 30);
    rdchk(REG_CAUSE, 16'h0088);
    $display("test reset pin done");
    // watchdog during sleep wakes without reset
    wr(REG_CAUSE, 16'h0000);
    @(posedge mclk);
    wdtTimeout <= 1'b1;
    hi = 0;
    wk = 0;
    repeat (10) begin
      @(posedge mclk);
      #1 hi += (systemReset !== 1'b0);
      wk += (wdtWakeup === 1'b1);
    end
    check(16'(wk), 16'h1);
    check(16'(hi), 16'h0);
    @(posedge mclk);
    wdtTimeout <= 1'b0;
    sleepMode <= 1'b0;
    rdchk(REG_CAUSE, 16'h0018);
    $display("test watchdog wake done");
    // supply dip in idle, no timeout, no monitor: fast release
    wr(REG_CAUSE, 16'h0000);
    @(posedge mclk);
    idleMode <= 1'b1;
    puTimeoutSel <= PU_NONE;
    bor_rel(500, 525);
    idleMode <= 1'b0;
    rdchk(REG_CAUSE, 16'h0002);
    $display("test brown-out done");
    // crystal with PLL that never starts, monitor on: trap and fast osc
    @(posedge mclk);
    oscGroupCfg <= GRP_PRI;
    primaryModeCfg <= PM_PLL4;
    slow <= 1'b1;
    fscmEn <= 1'b1;
    bor_rel(520, 550);
    check(16'(sawTrap), 16'h1);
    check(clkGroupSel, GRP_FRC);
    $display("test clock fail done");
    // monitor off and no clock: frozen until the oscillator starts
    @(posedge mclk);
    fscmEn <= 1'b0;
    @(posedge mclk);
    borBelow <= 1'b1;
    repeat (10) @(posedge mclk);
    borBelow <= 1'b0;
    wait_rel(1500, n);
    check(16'(n), 16'd1500);
    check(clkHold, 1'b1);
    rdchk(REG_STATUS, 16'({1'b1, ST_CLKW, 4'h2}));
    @(posedge mclk);
    slow <= 1'b0;
    rel(30, 60);
    check(clkGroupSel, GRP_PRI);
    check(primaryModeSel, PM_PLL4);
    $display("test frozen start done");
    // power-on pulse with the longest timeout code reruns the cold path
    wr(REG_CAUSE, 16'h0000);
    @(posedge mclk);
    porPulse <= 1'b1;
    puTimeoutSel <= 2'h3;
    repeat (10) @(posedge mclk);
    porPulse <= 1'b0;
    #1 check(systemReset, 1'b1);
    rel(580, 610);
    rdchk(REG_CAUSE, CAUSE_RST);
    check(clkGroupSel, GRP_PRI);
    $display("test power-on done");
    close_out();
  end
endmodule // rcs_reset_seq_bench
